//--- dv/ccl_analog_model.sv
// Purpose: Behavioural analog comparator core at the far side of the control block
// Assumes: Levels in millivolts, ideal comparator, channel n sits at 100*n+50 mV
// Notes:   Powered-off core drives low, so switching off a high output gives the control logic a falling edge
`timescale 1ns/1ps
module ccl_analog_model #(
	parameter int BANDGAP_MV = 1100,
	parameter int NEG_PIN_MV = 450
) (
	input  wire logic        power_off_i,
	input  wire logic        sel_bandgap_i,
	input  wire logic        sel_channel_i,
	input  wire logic [2:0]  channel_i,
	input  wire logic [15:0] pos_mv_i,
	output logic             cmp_raw_o
);
	// Converter mux only usable with its power reduction cleared
	localparam bit CONV_POWER_REDUCED = 1'b0;
	int pos_mv;
	int neg_mv;
	always_comb begin
		pos_mv = sel_bandgap_i ? BANDGAP_MV : int'(pos_mv_i);
		neg_mv = (sel_channel_i && !CONV_POWER_REDUCED) ? 100 * int'(channel_i) + 50 : NEG_PIN_MV;
		cmp_raw_o = !power_off_i && (pos_mv > neg_mv);
	end
endmodule

//--- dv/testbench.sv
// Purpose: Self-checking bench for the comparator control block
// Assumes: Wishbone classic master, 25 MHz clock
// Notes:   Fixed waits follow the stated result, flag and interrupt latencies
`timescale 1ns/1ps
module testbench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  adr = 4'h0;
	logic [31:0] dat = 32'h0;
	logic        we = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        glob = 1'b0;
	logic        vec = 1'b0;
	logic        pos_dig = 1'b0;
	logic        neg_dig = 1'b0;
	logic [15:0] pos_mv = 16'h0000;
	logic [31:0] dat_o, q;
	logic        ack, raw, pwr_off, bg, nsel, capt, pdig, ndig, pbuf, nbuf, irq;
	logic [2:0]  nch;
	logic        cap_irq_en = 1'b1;
	int          err_total = 0;
	int          num_checks = 0;
	int          cycles = 0;

	always #20 clk = ~clk;

	ccl_top dut_u (.CLK_SYS_I(clk), .SRST_I(rst), .ADR_I(adr), .DAT_I(dat), .DAT_O(dat_o), .WE_I(we),
		.SEL_I(4'hf), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .CMP_RAW_I(raw), .GLOBAL_IRQ_EN_I(glob),
		.VECTOR_ACK_I(vec), .POS_PIN_DIG_I(pos_dig), .NEG_PIN_DIG_I(neg_dig), .CMP_POWER_OFF_O(pwr_off),
		.POS_SEL_BANDGAP_O(bg), .NEG_SEL_CHANNEL_O(nsel), .NEG_CHANNEL_O(nch), .CAPTURE_O(capt),
		.POS_PIN_DIG_O(pdig), .NEG_PIN_DIG_O(ndig), .POS_BUF_OFF_O(pbuf), .NEG_BUF_OFF_O(nbuf), .IRQ_O(irq));

	ccl_analog_model model_u (.power_off_i(pwr_off), .sel_bandgap_i(bg), .sel_channel_i(nsel),
		.channel_i(nch), .pos_mv_i(pos_mv), .cmp_raw_o(raw));

	////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Pre-edge values are read right after each edge, so ack is sampled, not raced
	task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d, output logic [31:0] r);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		adr <= a;
		we  <= w;
		dat <= {24'h000000, d};
		do @(posedge clk); while (ack !== 1'b1);
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic settle();
		repeat (5) @(posedge clk);
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles > 6000) begin
			err_total++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		wb(4'h0, 1'b0, 8'h00, q); chk(q, 32'h0);
		wb(4'h4, 1'b0, 8'h00, q); chk(q, 32'h0);
		wb(4'h8, 1'b0, 8'h00, q); chk(q, 32'h0);
		wb(4'hc, 1'b0, 8'h00, q); chk(q, 32'h0);
		wb(4'h2, 1'b1, 8'hff, q);
		wb(4'h2, 1'b0, 8'h00, q); chk(q, 32'h0);
		// Interrupt stays disabled while the mode changes
		for (int m = 0; m < 4; m++) begin
			pos_mv <= 16'd100;
			settle();
			wb(4'h0, 1'b1, 8'(m), q);
			wb(4'h0, 1'b1, 8'h10 | 8'(m), q);
			pos_mv <= 16'd900;
			settle();
			wb(4'h0, 1'b0, 8'h00, q); chk(q[5:4], {1'b1, m == 0 || m == 3});
			wb(4'h0, 1'b1, 8'h10 | 8'(m), q);
			pos_mv <= 16'd100;
			settle();
			wb(4'h0, 1'b0, 8'h00, q); chk(q[5:4], {1'b0, m == 0 || m == 2});
		end
		wb(4'h0, 1'b1, 8'h1b, q);
		pos_mv <= 16'd900;
		settle();
		chk(irq, 1'b0);
		wb(4'h0, 1'b1, 8'h0b, q);
		wb(4'h0, 1'b0, 8'h00, q); chk(q[4], 1'b1);
		glob <= 1'b1;
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		vec <= 1'b1;
		@(posedge clk);
		vec <= 1'b0;
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		wb(4'h0, 1'b0, 8'h00, q); chk(q[4], 1'b0);
		pos_mv <= 16'd100;
		settle();
		pos_mv <= 16'd900;
		settle();
		chk(irq, 1'b1);
		wb(4'h0, 1'b1, 8'h1b, q);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		wb(4'h0, 1'b1, 8'h10, q);
		wb(4'h0, 1'b1, 8'h80, q);
		@(posedge clk);
		chk(pwr_off, 1'b1);
		settle();
		wb(4'h0, 1'b0, 8'h00, q); chk(q[5], 1'b0);
		pos_mv <= 16'd100;
		wb(4'h0, 1'b1, 8'h44, q);
		settle();
		wb(4'h0, 1'b0, 8'h00, q); chk({bg, capt & cap_irq_en, q[5]}, 3'h7);
		wb(4'h0, 1'b1, 8'h40, q);
		@(posedge clk);
		chk(capt, 1'b0);
		wb(4'h0, 1'b1, 8'h00, q);
		pos_mv <= 16'd500;
		wb(4'h4, 1'b1, 8'h40, q);
		for (int c = 0; c < 8; c++) begin
			wb(4'hc, 1'b1, 8'(c), q);
			settle();
			wb(4'h0, 1'b0, 8'h00, q); chk({nsel, nch, q[5]}, {1'b1, 3'(c), c < 5});
			wb(4'hc, 1'b1, 8'h80 | 8'(c), q);
			@(posedge clk);
			chk(nsel, 1'b0);
		end
		wb(4'hc, 1'b1, 8'h03, q);
		wb(4'h4, 1'b1, 8'h00, q);
		@(posedge clk);
		chk(nsel, 1'b0);
		pos_dig <= 1'b1;
		neg_dig <= 1'b1;
		settle();
		chk({pdig, ndig, pbuf, nbuf}, 4'hc);
		wb(4'h8, 1'b1, 8'h02, q);
		settle();
		chk({pdig, ndig, pbuf, nbuf}, 4'h9);
		wb(4'h8, 1'b1, 8'h03, q);
		settle();
		chk({pdig, ndig, pbuf, nbuf}, 4'h3);
		tally_and_finish();
	end
endmodule

//--- hdl/ccl_edge.sv
// Purpose: Event detector on the synchronised compare result
// Assumes: Input already in the system clock domain
// Notes:   One-cycle event pulse per qualifying transition
`timescale 1ns/1ps
module ccl_edge (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              level_i,
	input  ccl_pkg::ccl_mode_t     mode_i,
	output logic                   event_o
);
	logic prev;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			prev <= 1'b0;
		else
			prev <= level_i;
	end

	always_comb begin
		case (mode_i)
			ccl_pkg::CCL_MODE_TOGGLE: event_o = level_i ^ prev;
			ccl_pkg::CCL_MODE_FALL:   event_o = prev & ~level_i;
			ccl_pkg::CCL_MODE_RISE:   event_o = level_i & ~prev;
			default:                  event_o = 1'b0;
		endcase
	end
endmodule

//--- hdl/ccl_pkg.sv
// Purpose: Types shared by the comparator control block
// Assumes: Nothing beyond SystemVerilog
// Notes:   Constants live in ccl_regs.svh
package ccl_pkg;
	typedef enum logic [1:0] {
		CCL_MODE_TOGGLE   = 2'h0,
		CCL_MODE_RESERVED = 2'h1,
		CCL_MODE_FALL     = 2'h2,
		CCL_MODE_RISE     = 2'h3
	} ccl_mode_t;
endpackage

//--- hdl/ccl_regs.svh
// Purpose: Register offsets, field positions and reset values of the comparator control block
// Assumes: Wishbone classic, 32-bit data, byte addresses
// Notes:   Narrow registers sit in the low byte of their word
`ifndef CCL_REGS_SVH
`define CCL_REGS_SVH

`define CCL_ADR_W          4
`define CCL_OFF_CTRL       4'h0
`define CCL_OFF_CONVB      4'h4
`define CCL_OFF_DIDIS      4'h8
`define CCL_OFF_MUXSEL     4'hc

// Control/status fields
`define CCL_BIT_POWER_OFF  7
`define CCL_BIT_BANDGAP    6
`define CCL_BIT_RESULT     5
`define CCL_BIT_FLAG       4
`define CCL_BIT_IRQ_EN     3
`define CCL_BIT_CAPTURE    2
`define CCL_BIT_MODE_HI    1
`define CCL_BIT_MODE_LO    0
// Converter control B, converter mux/control copy
`define CCL_BIT_NEG_MUX    6
`define CCL_BIT_CONV_EN    7
`define CCL_BIT_VECTOR_ACK 6
// Input disable
`define CCL_BIT_NEG_DIS    1
`define CCL_BIT_POS_DIS    0

`define CCL_RST_BYTE       8'h00
`define CCL_SYNC_STAGES    2

`endif

//--- hdl/ccl_sync.sv
// Purpose: Two-flop synchroniser for a level from outside the clock domain
// Assumes: Synchronous active-high reset
// Notes:   First flop is read by the second only
`timescale 1ns/1ps
`include "ccl_regs.svh"
module ccl_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta   <= '0;
			sync_o <= '0;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule

//--- hdl/ccl_top.sv
// Purpose: Comparator control: result sync, event flag, interrupt, input routing
// Assumes: 25 MHz CLK_SYS_I, synchronous active-high SRST_I, Wishbone classic slave
// Notes:   Analog selection is output as control codes for the analog core
// How it works
// - Result high while positive exceeds negative
// - Raw output synchronised, one-two cycle latency
// - Mode: toggle, reserved, falling, rising
// - Flag set on chosen event regardless
// - Interrupt needs flag, enable, global enable
// - Vector execution clears the flag
// - Write one clears flag, zero keeps
// - Power-off bit removes comparator power
// - Bandgap select replaces positive pin
// - Capture route feeds timer capture input
// - Mux enable, converter off: channel picks negative
// - Otherwise the dedicated negative pin feeds
// - Input disable blanks pin digital buffer
// - Converter enable gates mux sharing
`timescale 1ns/1ps
`include "ccl_regs.svh"
module ccl_top (
	input  wire logic        CLK_SYS_I,
	input  wire logic        SRST_I,
	input  wire logic [3:0]  ADR_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	input  wire logic        WE_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	output logic             ACK_O,
	input  wire logic        CMP_RAW_I,
	input  wire logic        GLOBAL_IRQ_EN_I,
	input  wire logic        VECTOR_ACK_I,
	input  wire logic        POS_PIN_DIG_I,
	input  wire logic        NEG_PIN_DIG_I,
	output logic             CMP_POWER_OFF_O,
	output logic             POS_SEL_BANDGAP_O,
	output logic             NEG_SEL_CHANNEL_O,
	output logic [2:0]       NEG_CHANNEL_O,
	output logic             CAPTURE_O,
	output logic             POS_PIN_DIG_O,
	output logic             NEG_PIN_DIG_O,
	output logic             POS_BUF_OFF_O,
	output logic             NEG_BUF_OFF_O,
	output logic             IRQ_O
);
	////////////////////////////////////////////////////////////////////////
	logic [7:0]          ctrl;
	logic                flag;
	logic                neg_mux;
	logic [1:0]          didis;
	logic [2:0]          channel_select;
	logic                conv_en;
	logic                result;
	logic                evt;
	logic [1:0]          pin_sync;
	logic                wr;
	logic                rd_ack_cycle;
	logic [7:0]          next_rdata;

	assign wr           = CYC_I & STB_I & WE_I & ~ACK_O & SEL_I[0];
	assign rd_ack_cycle = CYC_I & STB_I & ~ACK_O;

	function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
		return adr == off;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Comparator is an analog core; its result is asynchronous here
	ccl_sync #(.WIDTH(1)) u_cmp_sync (
		.clk_i   (CLK_SYS_I),
		.rst_i   (SRST_I),
		.async_i (CMP_RAW_I),
		.sync_o  (result)
	);

	ccl_sync #(.WIDTH(2)) u_pin_sync (
		.clk_i   (CLK_SYS_I),
		.rst_i   (SRST_I),
		.async_i ({NEG_PIN_DIG_I, POS_PIN_DIG_I}),
		.sync_o  (pin_sync)
	);

	// Power-off edges still count; software masks the interrupt first
	ccl_edge u_edge (
		.clk_i   (CLK_SYS_I),
		.rst_i   (SRST_I),
		.level_i (result),
		.mode_i  (ccl_pkg::ccl_mode_t'(ctrl[`CCL_BIT_MODE_HI:`CCL_BIT_MODE_LO])),
		.event_o (evt)
	);

	////////////////////////////////////////////////////////////////////////
	// Control bits; flag and result are held separately
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			ctrl <= `CCL_RST_BYTE;
		end else if (wr && hit(ADR_I, `CCL_OFF_CTRL)) begin
			ctrl <= DAT_I[7:0];
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			neg_mux        <= 1'b0;
			didis          <= 2'h0;
			channel_select <= 3'h0;
			conv_en        <= 1'b0;
		end else if (wr) begin
			if (hit(ADR_I, `CCL_OFF_CONVB))
				neg_mux <= DAT_I[`CCL_BIT_NEG_MUX];
			if (hit(ADR_I, `CCL_OFF_DIDIS))
				didis <= DAT_I[`CCL_BIT_NEG_DIS:`CCL_BIT_POS_DIS];
			if (hit(ADR_I, `CCL_OFF_MUXSEL)) begin
				channel_select <= DAT_I[2:0];
				conv_en        <= DAT_I[`CCL_BIT_CONV_EN];
			end
		end
	end

	// Set wins over both clears so no event is lost
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I)
			flag <= 1'b0;
		else if (evt)
			flag <= 1'b1;
		else if (VECTOR_ACK_I)
			flag <= 1'b0;
		else if (wr && hit(ADR_I, `CCL_OFF_CTRL) && DAT_I[`CCL_BIT_FLAG])
			flag <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_rdata = 8'h00;
		if (hit(ADR_I, `CCL_OFF_CTRL)) begin
			next_rdata                = ctrl;
			next_rdata[`CCL_BIT_RESULT] = result;
			next_rdata[`CCL_BIT_FLAG]   = flag;
		end else if (hit(ADR_I, `CCL_OFF_CONVB)) begin
			next_rdata[`CCL_BIT_NEG_MUX] = neg_mux;
		end else if (hit(ADR_I, `CCL_OFF_DIDIS)) begin
			next_rdata[`CCL_BIT_NEG_DIS:`CCL_BIT_POS_DIS] = didis;
		end else if (hit(ADR_I, `CCL_OFF_MUXSEL)) begin
			next_rdata[2:0]              = channel_select;
			next_rdata[`CCL_BIT_CONV_EN] = conv_en;
		end
	end

	// One-cycle-late ack; unmapped addresses ack and read zero
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			ACK_O <= 1'b0;
			DAT_O <= 32'h0;
		end else begin
			ACK_O <= rd_ack_cycle;
			DAT_O <= {24'h0, next_rdata};
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			CMP_POWER_OFF_O   <= 1'b0;
			POS_SEL_BANDGAP_O <= 1'b0;
			NEG_SEL_CHANNEL_O <= 1'b0;
			NEG_CHANNEL_O     <= 3'h0;
			CAPTURE_O         <= 1'b0;
			IRQ_O             <= 1'b0;
		end else begin
			CMP_POWER_OFF_O   <= ctrl[`CCL_BIT_POWER_OFF];
			POS_SEL_BANDGAP_O <= ctrl[`CCL_BIT_BANDGAP];
			NEG_SEL_CHANNEL_O <= neg_mux & ~conv_en;
			NEG_CHANNEL_O     <= channel_select;
			CAPTURE_O         <= ctrl[`CCL_BIT_CAPTURE] & result;
			IRQ_O             <= flag & ctrl[`CCL_BIT_IRQ_EN] & GLOBAL_IRQ_EN_I;
		end
	end

	// Disabled buffers read zero toward the port register
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I) begin
			POS_PIN_DIG_O <= 1'b0;
			NEG_PIN_DIG_O <= 1'b0;
			POS_BUF_OFF_O <= 1'b0;
			NEG_BUF_OFF_O <= 1'b0;
		end else begin
			POS_PIN_DIG_O <= pin_sync[0] & ~didis[`CCL_BIT_POS_DIS];
			NEG_PIN_DIG_O <= pin_sync[1] & ~didis[`CCL_BIT_NEG_DIS];
			POS_BUF_OFF_O <= didis[`CCL_BIT_POS_DIS];
			NEG_BUF_OFF_O <= didis[`CCL_BIT_NEG_DIS];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic past_valid;
	always_ff @(posedge CLK_SYS_I) begin
		if (SRST_I)
			past_valid <= 1'b0;
		else
			past_valid <= 1'b1;
	end

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (SRST_I || !past_valid);

	AST_RESULT_LAT: assert property ($rose(CMP_RAW_I) ##1 CMP_RAW_I[*2] |-> result)
		else $error("compare result not synced in time");
	AST_RISE_EVT: assert property (ctrl[1:0] == 2'h3 && $rose(result) |=> flag)
		else $error("rising event did not set flag");
	AST_FALL_EVT: assert property (ctrl[1:0] == 2'h2 && $fell(result) |=> flag)
		else $error("falling event did not set flag");
	AST_RSVD: assert property (ctrl[1:0] == 2'h1 |-> !evt)
		else $error("reserved mode produced event");
	AST_IRQ: assert property (##1 IRQ_O == $past(flag & ctrl[3] & GLOBAL_IRQ_EN_I))
		else $error("irq does not follow flag and enables");
	AST_VEC_CLR: assert property (VECTOR_ACK_I && !evt |=> !flag)
		else $error("vector did not clear flag");
	AST_W0_KEEP: assert property (flag && !VECTOR_ACK_I && !(wr && ADR_I == 4'h0 && DAT_I[4]) |=> flag)
		else $error("flag lost without clear");
	AST_NEG_SEL: assert property (neg_mux && conv_en |=> !NEG_SEL_CHANNEL_O)
		else $error("channel chosen while converter on");
	AST_DIS: assert property (didis[0] |=> !POS_PIN_DIG_O)
		else $error("disabled input read nonzero");
	AST_ACK: assert property (ACK_O |=> !ACK_O)
		else $error("ack held two cycles");

	COV_TOGGLE: cover property (ctrl[1:0] == 2'h0 && evt);
	COV_IRQ: cover property ($rose(IRQ_O));
	COV_CAP: cover property (CAPTURE_O);
endmodule
